/* File: design/pir_pkg.sv */
// shared constants of the processor interconnect register bank:
// register indices, field positions, reset values and state codes.
// assumes the bank sits on a 32-bit APB slave port, one word per index.
package pir_pkg;

	// ------------------------------------------------------------
	// register indices; the byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_MCHK      = 8'h26;
	localparam logic [7:0] IDX_ITE       = 8'h80;
	localparam logic [7:0] IDX_OTHER_CPU = 8'h81;
	localparam logic [7:0] IDX_FAULT     = 8'h82;
	localparam logic [7:0] IDX_SILO      = 8'h83;
	localparam logic [7:0] IDX_TO_ADDR   = 8'h84;
	localparam logic [7:0] IDX_CACHE     = 8'h85;
	localparam logic [7:0] IDX_REV_ONE   = 8'h86;
	localparam logic [7:0] IDX_REV_TWO   = 8'h87;
	localparam logic [7:0] IDX_CLR_TO    = 8'h88;
	localparam logic [7:0] IDX_FLUSH     = 8'h89;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h8A;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h8B;

	// ------------------------------------------------------------
	// field widths and positions
	// ------------------------------------------------------------
	localparam int ITE_W        = 8;
	localparam int CACHE_W      = 8;
	localparam int CACHE_ON_BIT = 0;
	localparam int MCHK_W       = 4;
	localparam int EVT_W        = 4;
	localparam int FLT_FAULT    = 0;
	localparam int FLT_TIMEOUT  = 1;
	localparam int FLT_LOCKED   = 2;
	localparam int FLT_REARM    = 2;
	localparam int FLT_CNT_LSB  = 8;
	localparam int EVT_FAULT    = 0;
	localparam int EVT_TIMEOUT  = 1;
	localparam int EVT_MCHK     = 2;
	localparam int EVT_FLUSHED  = 3;
	localparam int SILO_DEPTH   = 256;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [ITE_W-1:0]   RST_ITE   = 8'h00;
	localparam logic [CACHE_W-1:0] RST_CACHE = 8'h00;
	localparam logic [EVT_W-1:0]   RST_MASK  = 4'h0;
	localparam logic [31:0]        RST_WORD  = 32'h00000000;

	// ------------------------------------------------------------
	// bus answer state, gray along idle -> answer -> idle
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PIR_IDLE   = 2'b00,
		PIR_ANSWER = 2'b01
	} pir_apb_t;

endpackage

/* File: design/pir_evt.sv */
// sticky event flags with a mask onto one level interrupt.
// assumes set and clear are single-cycle strobes in the pclk domain.
`timescale 1ns/100ps
module pir_evt
	import pir_pkg::*;
#(
	parameter int N = EVT_W
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	// flag control
	input  wire logic [N-1:0] set,
	input  wire logic [N-1:0] clr,
	input  wire logic [N-1:0] mask,
	// results
	output logic      [N-1:0] status,
	output logic              irq
);

	// ------------------------------------------------------------
	// per-bit flags
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			// a set in the clearing cycle wins so no event is lost
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status[i] <= 1'b0;
				end else if (clk_en) begin
					status[i] <= set[i] | (status[i] & ~clr[i]);
				end
			end
		end
	endgenerate

	// level output straight from a flop, high while any unmasked flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |(status & mask);
		end
	end

endmodule

/* File: design/pir_silo.sv */
// transaction history silo: circular record of interconnect words
// that freezes on a fault and then gives up one entry per pop.
// assumes depth is a power of two and pop comes only from the bus.
`timescale 1ns/100ps
module pir_silo
	import pir_pkg::*;
#(
	parameter int DEPTH = SILO_DEPTH,
	parameter int W     = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clk_en,
	// recording side
	input  wire logic         push,
	input  wire logic [W-1:0] push_data,
	input  wire logic         lock_req,
	input  wire logic         rearm,
	// reading side
	input  wire logic         pop,
	output logic      [W-1:0] head,
	output logic      [AW:0]  count,
	output logic              locked
);

	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic          do_push;
	logic          do_pop;
	logic          full;

	// a frozen silo takes nothing new; pops only drain a frozen one
	assign full    = (count == (AW+1)'(DEPTH));
	assign do_push = push & ~locked;                    // [RULE7]
	assign do_pop  = pop & locked & (count != '0);      // [RULE9]
	assign head    = mem[rd_ptr];

	// storage has no reset, it is only read after being written
	always_ff @(posedge pclk) begin
		if (clk_en && do_push) begin
			mem[wr_ptr] <= push_data;
		end
	end

	// pointers: when full the oldest entry is overwritten
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clk_en) begin
			if (rearm) begin
				rd_ptr <= wr_ptr;
				count  <= '0;
			end else if (do_push) begin
				wr_ptr <= wr_ptr + 1'b1;
				if (full) begin
					rd_ptr <= rd_ptr + 1'b1;
				end else begin
					count <= count + 1'b1;
				end
			end else if (do_pop) begin
				rd_ptr <= rd_ptr + 1'b1;
				count  <= count - 1'b1;
			end
		end
	end

	// freeze on fault; a fault in the rearm cycle still freezes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked <= 1'b0;
		end else if (clk_en) begin
			locked <= lock_req | (locked & ~rearm);      // [RULE8]
		end
	end

endmodule

/* File: design/pir_regs.sv */
// processor interconnect register bank: interrupt type enable,
// fault summary, transaction silo, timeout address, cache control,
// revision readout and command registers behind an APB slave.
// assumes interconnect strobes are synchronous one-cycle pulses.
//
// Overview of operation
// [RULE1] writes to command registers act by the write alone; data ignored
// [RULE2] bits defined as zero on read always read back zero
// [RULE3] zero-on-write bits are stored unchecked and read back as written
// [RULE4] don't-care bits on write have no effect at all
// [RULE5] interrupt type enable is write-only and selects accepted classes
// [RULE6] fault status gathers interconnect fault and timeout summary
// [RULE7] silo is read-only and records up to 256 transactions
// [RULE8] silo is set up to freeze on a detected interconnect fault
// [RULE9] each read of a frozen silo returns one entry and removes it
// [RULE10] a timed-out transaction's address is caught in a register
// [RULE11] cache enable is read/write and governs cache use
// [RULE12] both revision registers are read-only fixed values
// [RULE13] clear-timeout write clears timeout flag; flush write drains
// [RULE14] interrupt-other-cpu write raises a request to the peer cpu
`timescale 1ns/100ps
module pir_regs
	import pir_pkg::*;
#(
	parameter int          ADDR_W  = 12,
	parameter int          DEPTH   = SILO_DEPTH,
	parameter logic [31:0] REV_ONE = 32'h00000001, // arbitrary value
	parameter logic [31:0] REV_TWO = 32'h00000002  // arbitrary value
) (
	// clock, reset and clock enable
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              clk_en,
	// apb slave
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// memory interconnect watch
	input  wire logic              ic_txn_valid,
	input  wire logic [31:0]       ic_txn_word,
	input  wire logic [31:0]       ic_txn_addr,
	input  wire logic              ic_fault,
	input  wire logic              ic_timeout,
	input  wire logic [MCHK_W-1:0] mc_event,
	// write buffer
	input  wire logic              wb_empty,
	output logic                   wb_flush_req,
	// processor controls
	output logic      [ITE_W-1:0]  int_type_enable,
	output logic                   cache_enable,
	output logic                   other_cpu_irq,
	// interrupt
	output logic                   irq
);

	localparam int AW = $clog2(DEPTH);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	pir_apb_t             state;
	pir_apb_t             next_state;
	logic [7:0]           idx;
	logic                 in_range;
	logic                 hit;
	logic                 setup;
	logic                 wr_go;
	logic                 rd_go;
	logic [31:0]          next_rdata;
	logic [CACHE_W-1:0]   cache_ctl;
	logic [MCHK_W-1:0]    mchk;
	logic                 flt_fault;
	logic                 flt_timeout;
	logic [31:0]          to_addr;
	logic [EVT_W-1:0]     irq_mask;
	logic [EVT_W-1:0]     irq_stat;
	logic [EVT_W-1:0]     evt_set;
	logic [EVT_W-1:0]     evt_clr;
	logic                 flush_done;
	logic [31:0]          silo_head;
	logic [AW:0]          silo_count;
	logic                 silo_locked;
	logic                 silo_rearm;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	// word index from the byte address; upper bits must be clear
	assign idx      = paddr[9:2];
	assign in_range = (paddr[ADDR_W-1:10] == '0);

	// mapped indices only; anything else answers with an error
	always_comb begin
		hit = 1'b0;
		if (in_range) begin
			case (idx)
				IDX_MCHK, IDX_ITE, IDX_OTHER_CPU, IDX_FAULT,
				IDX_SILO, IDX_TO_ADDR, IDX_CACHE, IDX_REV_ONE,
				IDX_REV_TWO, IDX_CLR_TO, IDX_FLUSH,
				IDX_IRQ_STAT, IDX_IRQ_MASK: begin
					hit = 1'b1;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// apb handshake
	// ------------------------------------------------------------

	// no wait state: data is registered during setup so that
	// prdata, pready and pslverr all come straight from flops
	assign setup = psel & ~penable;
	assign wr_go = (state == PIR_ANSWER) & psel & penable & pwrite & hit;
	assign rd_go = (state == PIR_ANSWER) & psel & penable & ~pwrite & hit;

	// next answer state
	always_comb begin
		case (state)
			PIR_IDLE: begin
				next_state = setup ? PIR_ANSWER : PIR_IDLE;
			end
			PIR_ANSWER: begin
				next_state = PIR_IDLE;
			end
			default: begin
				next_state = PIR_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= PIR_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// answer flops; pready stands for the access cycle only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RST_WORD;
		end else if (clk_en) begin
			if (state == PIR_IDLE && setup) begin
				pready  <= 1'b1;
				pslverr <= ~hit;
				prdata  <= pwrite ? RST_WORD : next_rdata;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
				prdata  <= RST_WORD;
			end
		end
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------

	// undefined bits are left at zero on every path
	always_comb begin
		next_rdata = RST_WORD;                           // [RULE2]
		if (in_range) begin
			case (idx)
				IDX_MCHK: begin
					next_rdata[MCHK_W-1:0] = mchk;
				end
				IDX_FAULT: begin
					next_rdata[FLT_FAULT]   = flt_fault;   // [RULE6]
					next_rdata[FLT_TIMEOUT] = flt_timeout;
					next_rdata[FLT_LOCKED]  = silo_locked;
					next_rdata[FLT_CNT_LSB +: AW+1] = silo_count;
				end
				IDX_SILO: begin
					next_rdata = silo_head;                // [RULE9]
				end
				IDX_TO_ADDR: begin
					next_rdata = to_addr;                  // [RULE10]
				end
				IDX_CACHE: begin
					next_rdata[CACHE_W-1:0] = cache_ctl;   // [RULE3]
				end
				IDX_REV_ONE: begin
					next_rdata = REV_ONE;                  // [RULE12]
				end
				IDX_REV_TWO: begin
					next_rdata = REV_TWO;                  // [RULE12]
				end
				IDX_IRQ_STAT: begin
					next_rdata[EVT_W-1:0] = irq_stat;
				end
				IDX_IRQ_MASK: begin
					next_rdata[EVT_W-1:0] = irq_mask;
				end
				// write-only and command registers read as zero
				default: begin
					next_rdata = RST_WORD;                 // [RULE2]
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// software controls
	// ------------------------------------------------------------

	// interrupt type enable: write-only, reads return zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_type_enable <= RST_ITE;
		end else if (clk_en && wr_go && idx == IDX_ITE) begin
			int_type_enable <= pwdata[ITE_W-1:0];       // [RULE5]
		end
	end

	// cache control: the whole low byte is kept as written, so
	// bits software must write as zero come back unchanged;
	// the upper bits are don't-care and are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cache_ctl <= RST_CACHE;
		end else if (clk_en && wr_go && idx == IDX_CACHE) begin
			cache_ctl <= pwdata[CACHE_W-1:0];           // [RULE3] [RULE4]
		end
	end

	// output flop so the cache switch is glitch free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cache_enable <= 1'b0;
		end else if (clk_en) begin
			cache_enable <= cache_ctl[CACHE_ON_BIT];    // [RULE11]
		end
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= RST_MASK;
		end else if (clk_en && wr_go && idx == IDX_IRQ_MASK) begin
			irq_mask <= pwdata[EVT_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// command registers
	// ------------------------------------------------------------

	// peer interrupt: one pulse per write, data not looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			other_cpu_irq <= 1'b0;
		end else if (clk_en) begin
			other_cpu_irq <= wr_go && idx == IDX_OTHER_CPU; // [RULE1] [RULE14]
		end
	end

	// flush request holds until the buffer reports empty; a new
	// flush write while one is pending simply extends it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_flush_req <= 1'b0;
		end else if (clk_en) begin
			if (wr_go && idx == IDX_FLUSH) begin
				wb_flush_req <= 1'b1;                   // [RULE1] [RULE13]
			end else if (wb_empty) begin
				wb_flush_req <= 1'b0;                   // [RULE13]
			end
		end
	end

	assign flush_done = wb_flush_req & wb_empty &
		~(wr_go && idx == IDX_FLUSH);

	// ------------------------------------------------------------
	// interconnect fault summary
	// ------------------------------------------------------------

	// fault flag: set by the interconnect, write one to clear;
	// a new fault in the clearing cycle keeps the flag set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt_fault <= 1'b0;
		end else if (clk_en) begin
			flt_fault <= ic_fault | (flt_fault &
				~(wr_go && idx == IDX_FAULT &&
				pwdata[FLT_FAULT]));                    // [RULE6]
		end
	end

	// timeout flag: cleared only by any write to clear-timeout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flt_timeout <= 1'b0;
		end else if (clk_en) begin
			flt_timeout <= ic_timeout | (flt_timeout &
				~(wr_go && idx == IDX_CLR_TO));         // [RULE1] [RULE13]
		end
	end

	// timed-out transaction address, latest one wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			to_addr <= RST_WORD;
		end else if (clk_en && ic_timeout) begin
			to_addr <= ic_txn_addr;                     // [RULE10]
		end
	end

	// machine check causes: sticky, write one to clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mchk <= '0;
		end else if (clk_en) begin
			if (wr_go && idx == IDX_MCHK) begin
				mchk <= mc_event | (mchk & ~pwdata[MCHK_W-1:0]);
			end else begin
				mchk <= mc_event | mchk;
			end
		end
	end

	// ------------------------------------------------------------
	// transaction silo
	// ------------------------------------------------------------

	// writing one to the rearm bit restarts recording
	assign silo_rearm = wr_go && idx == IDX_FAULT && pwdata[FLT_REARM];

	pir_silo #(
		.DEPTH     (DEPTH),
		.W         (32),
		.AW        (AW)
	) u_silo (
		.pclk      (pclk),
		.presetn   (presetn),
		.clk_en    (clk_en),
		.push      (ic_txn_valid),                      // [RULE7]
		.push_data (ic_txn_word),
		.lock_req  (ic_fault),                          // [RULE8]
		.rearm     (silo_rearm),
		.pop       (rd_go && idx == IDX_SILO),          // [RULE9]
		.head      (silo_head),
		.count     (silo_count),
		.locked    (silo_locked)
	);

	// ------------------------------------------------------------
	// interrupt flags
	// ------------------------------------------------------------

	// events feeding the sticky status bits
	always_comb begin
		evt_set              = '0;
		evt_set[EVT_FAULT]   = ic_fault;
		evt_set[EVT_TIMEOUT] = ic_timeout;
		evt_set[EVT_MCHK]    = |mc_event;
		evt_set[EVT_FLUSHED] = flush_done;
	end

	// write one to clear in the status register
	assign evt_clr = (wr_go && idx == IDX_IRQ_STAT) ?
		pwdata[EVT_W-1:0] : '0;

	pir_evt #(
		.N       (EVT_W)
	) u_evt (
		.pclk    (pclk),
		.presetn (presetn),
		.clk_en  (clk_en),
		.set     (evt_set),
		.clr     (evt_clr),
		.mask    (irq_mask),
		.status  (irq_stat),
		.irq     (irq)
	);

endmodule

/* File: sim/pir_regs_properties.sv */
// checker for the register bank: bus answers and command side effects.
// assumes it is bound to pir_regs and sees only that module's ports.
`timescale 1ns/100ps
module pir_regs_properties
	import pir_pkg::*;
#(
	parameter int          ADDR_W  = 12,
	parameter logic [31:0] REV_ONE = 32'h00000001,
	parameter logic [31:0] REV_TWO = 32'h00000002
) (
	// clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              clk_en,
	// apb
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	// controls
	input wire logic              wb_empty,
	input wire logic              wb_flush_req,
	input wire logic [ITE_W-1:0]  int_type_enable,
	input wire logic              cache_enable,
	input wire logic              other_cpu_irq
);
	// ---------------------------------------------------------------
	// decoded access at the edge where it takes effect
	// ---------------------------------------------------------------
	logic       acc;
	logic       peer_wr;
	logic [7:0] idx;
	assign acc = psel && penable && pready && clk_en && paddr[11:10] == 2'b00;
	assign idx = paddr[9:2];
	assign peer_wr = acc && pwrite && idx == IDX_OTHER_CPU;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ite_follows: assert property (
		acc && pwrite && idx == IDX_ITE |=> int_type_enable == $past(pwdata[7:0]))
		else $error("type enable output does not follow write");
	a_ite_hidden: assert property (
		acc && !pwrite && idx == IDX_ITE |-> prdata == 32'h00000000)
		else $error("type enable register readable");
	a_cmd_read_zero: assert property (
		acc && !pwrite && (idx == IDX_OTHER_CPU || idx == IDX_CLR_TO ||
		idx == IDX_FLUSH) |-> prdata == 32'h00000000)
		else $error("command register reads nonzero");
	a_cache_high_zero: assert property (
		acc && !pwrite && idx == IDX_CACHE |-> prdata[31:8] == 24'h000000)
		else $error("cache control upper bits nonzero");
	a_cache_drives: assert property (
		acc && pwrite && idx == IDX_CACHE |-> ##2
		cache_enable == $past(pwdata[0], 2))
		else $error("cache enable does not follow register");
	a_rev_fixed: assert property (
		acc && !pwrite && (idx == IDX_REV_ONE || idx == IDX_REV_TWO) |->
		prdata == ((idx == IDX_REV_ONE) ? REV_ONE : REV_TWO))
		else $error("revision value wrong");
	a_peer_pulse: assert property (
		peer_wr |=> other_cpu_irq ##1 !other_cpu_irq)
		else $error("peer request not a single pulse");
	a_peer_cause: assert property (
		$rose(other_cpu_irq) |-> $past(peer_wr))
		else $error("peer request without write");
	a_flush_starts: assert property (
		acc && pwrite && idx == IDX_FLUSH |=> wb_flush_req)
		else $error("flush request not raised");
	a_flush_waits: assert property (
		wb_flush_req && !wb_empty && clk_en |=> wb_flush_req)
		else $error("flush request dropped before drain");

	// main scenarios reached
	c_silo_pop: cover property (acc && !pwrite && idx == IDX_SILO);
	c_flush_done: cover property (wb_flush_req ##1 !wb_flush_req);
	c_peer: cover property (other_cpu_irq);
endmodule

bind pir_regs pir_regs_properties #(
	.ADDR_W(ADDR_W), .REV_ONE(REV_ONE), .REV_TWO(REV_TWO)
) pir_regs_properties_i (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .wb_empty(wb_empty),
	.wb_flush_req(wb_flush_req), .int_type_enable(int_type_enable),
	.cache_enable(cache_enable), .other_cpu_irq(other_cpu_irq)
);

/* File: sim/pir_ic_model.sv */
// memory interconnect and write buffer model seen by the register bank.
// assumes the bench calls its tasks; one pulse per call.
`timescale 1ns/100ps
module pir_ic_model
	import pir_pkg::*;
#(
	parameter int STALL = 6
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	output logic                   ic_txn_valid,
	output logic      [31:0]       ic_txn_word,
	output logic      [31:0]       ic_txn_addr,
	output logic                   ic_fault,
	output logic                   ic_timeout,
	output logic      [MCHK_W-1:0] mc_event,
	input  wire logic              wb_flush_req,
	output logic                   wb_empty
);
	int cnt;
	// released word and address lines show the inverse, so stale values never match
	initial begin
		ic_txn_valid = 1'b0;
		ic_txn_word = 32'h0;
		ic_txn_addr = 32'h0;
		ic_fault = 1'b0;
		ic_timeout = 1'b0;
		mc_event = '0;
	end
	task automatic txn(input logic [31:0] w);
		@(posedge pclk);
		ic_txn_valid <= 1'b1;
		ic_txn_word <= w;
		@(posedge pclk);
		ic_txn_valid <= 1'b0;
		ic_txn_word <= ~w;
	endtask
	task automatic fault();
		@(posedge pclk);
		ic_fault <= 1'b1;
		@(posedge pclk);
		ic_fault <= 1'b0;
	endtask
	task automatic timeout(input logic [31:0] a);
		@(posedge pclk);
		ic_timeout <= 1'b1;
		ic_txn_addr <= a;
		@(posedge pclk);
		ic_timeout <= 1'b0;
		ic_txn_addr <= ~a;
	endtask
	task automatic mce(input logic [MCHK_W-1:0] m);
		@(posedge pclk);
		mc_event <= m;
		@(posedge pclk);
		mc_event <= '0;
	endtask
	// buffer holds writes; a flush drains them slowly, then refills
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 0;
			wb_empty <= 1'b0;
		end else if (wb_flush_req && !wb_empty) begin
			if (cnt == STALL) wb_empty <= 1'b1;
			else cnt <= cnt + 1;
		end else if (!wb_flush_req) begin
			cnt <= 0;
			wb_empty <= 1'b0;
		end
	end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the register bank over apb.
// assumes the interconnect model drives the watch inputs.
`timescale 1ns/100ps
module testbench
	import pir_pkg::*;
;
	localparam logic [31:0] REV1 = 32'h00000011; // arbitrary value
	localparam logic [31:0] REV2 = 32'h00000022; // arbitrary value
	logic        pclk, presetn, clk_en, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, ic_txn_word, ic_txn_addr, r;
	logic        pready, pslverr, ic_txn_valid, ic_fault, ic_timeout;
	logic        wb_empty, wb_flush_req, cache_enable, other_cpu_irq, irq;
	logic [3:0]  mc_event;
	logic [7:0]  int_type_enable;
	logic [31:0] words [6];
	logic [32:0] expq [$];
	int          fail_count, checks_done, cycles, k;
	integer      seed;

	pir_regs #(.REV_ONE(REV1), .REV_TWO(REV2)) pir_regs_i (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ic_txn_valid(ic_txn_valid), .ic_txn_word(ic_txn_word),
		.ic_txn_addr(ic_txn_addr), .ic_fault(ic_fault),
		.ic_timeout(ic_timeout), .mc_event(mc_event), .wb_empty(wb_empty),
		.wb_flush_req(wb_flush_req), .int_type_enable(int_type_enable),
		.cache_enable(cache_enable), .other_cpu_irq(other_cpu_irq), .irq(irq));
	pir_ic_model pir_ic_model_i (
		.pclk(pclk), .presetn(presetn), .ic_txn_valid(ic_txn_valid),
		.ic_txn_word(ic_txn_word), .ic_txn_addr(ic_txn_addr),
		.ic_fault(ic_fault), .ic_timeout(ic_timeout), .mc_event(mc_event),
		.wb_flush_req(wb_flush_req), .wb_empty(wb_empty));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; a read notes its expected {error, data}
	task automatic apb(input logic is_wr, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] exp);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= is_wr;
		paddr <= a;
		pwdata <= d;
		if (!is_wr) expq.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		apb(1'b0, {2'b00, i, 2'b00}, 32'h0, {1'b0, e});
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	// read results taken off the queue as they appear
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
			check({pslverr, prdata}, expq.pop_front());
	end
	// hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		seed = 32'h9e7a;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(IDX_CACHE, 32'h0);
		rd(IDX_IRQ_MASK, 32'h0);
		rd(IDX_REV_ONE, REV1);
		wr(IDX_REV_TWO, 32'hFFFFFFFF);
		rd(IDX_REV_TWO, REV2);
		apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
		apb(1'b0, 12'hE18, 32'h0, {1'b1, 32'h0});
		tdone("reset and fixed values");
		for (k = 0; k < 2; k++) begin
			r = $random(seed);
			wr(IDX_ITE, {24'h0, r[7:0]});
			@(negedge pclk);
			check({25'h0, int_type_enable}, {25'h0, r[7:0]});
			rd(IDX_ITE, 32'h0);
			wr(IDX_CACHE, {r[31:1], k[0]});
			rd(IDX_CACHE, {24'h0, r[7:1], k[0]});
			@(negedge pclk);
			check({32'h0, cache_enable}, {32'h0, k[0]});
			wr(IDX_OTHER_CPU, r);
		end
		tdone("controls");
		for (k = 0; k < 6; k++) words[k] = $random(seed);
		for (k = 0; k < 5; k++) pir_ic_model_i.txn(words[k]);
		pir_ic_model_i.fault();
		pir_ic_model_i.txn(words[5]);
		rd(IDX_FAULT, 32'h00000505);
		for (k = 0; k < 5; k++) rd(IDX_SILO, words[k]);
		rd(IDX_FAULT, 32'h00000005);
		wr(IDX_FAULT, 32'h00000005);
		rd(IDX_FAULT, 32'h0);
		tdone("silo");
		r = $random(seed);
		pir_ic_model_i.timeout(r);
		rd(IDX_TO_ADDR, r);
		rd(IDX_FAULT, 32'h00000002);
		wr(IDX_CLR_TO, $random(seed));
		rd(IDX_CLR_TO, 32'h0);
		rd(IDX_FAULT, 32'h0);
		tdone("timeout");
		pir_ic_model_i.mce(4'hA);
		rd(IDX_MCHK, 32'h0000000A);
		rd(IDX_IRQ_STAT, 32'h00000007);
		check({32'h0, irq}, 33'h0);
		wr(IDX_IRQ_MASK, 32'h00000004);
		rd(IDX_IRQ_MASK, 32'h00000004);
		check({32'h0, irq}, 33'h1);
		wr(IDX_IRQ_STAT, 32'h00000007);
		wr(IDX_MCHK, 32'h0000000F);
		rd(IDX_MCHK, 32'h0);
		check({32'h0, irq}, 33'h0);
		tdone("interrupts");
		wr(IDX_IRQ_MASK, 32'h00000008);
		wr(IDX_FLUSH, $random(seed));
		@(negedge pclk);
		check({32'h0, wb_flush_req}, 33'h1);
		k = 0;
		while (irq !== 1'b1 && k < 50) begin
			@(posedge pclk);
			k++;
		end
		check({32'h0, irq}, 33'h1);
		rd(IDX_IRQ_STAT, 32'h00000008);
		tdone("flush");
		report_and_stop();
	end
endmodule
